// file: opcode_decoder_core_ops.sv
`include "decoder_cfg.svh"
module opcode_decoder_core_ops
	import decoder_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic in_valid,
	input wire logic [7:0] in_byte,
	input wire logic op32,
	output logic dec_valid,
	output logic dec_invalid,
	output dec_out_t dec
);

	state_t state_reg, state_next;
	logic [7:0] opc_reg;
	logic [7:0] modrm_reg;
	class_t cls_reg;
	op_t op_reg;
	logic dec_valid_reg;
	logic dec_invalid_reg;
	dec_out_t dec_reg;
	dec_out_t dec_next;
	class_t cls_in;
	op_t grp_op;
	logic emit, bad;

	// Stage selection
	wire logic fresh = state_reg == st_opcode || state_reg == st_escape;
	wire logic at_modrm = state_reg == st_modrm;
	wire logic opc_take = state_reg == st_opcode && in_valid;
	wire logic [7:0] use_opc = fresh ? in_byte : opc_reg;
	wire class_t use_cls = fresh ? cls_in : cls_reg;
	wire op_t use_op = fresh ? cls_in.op : (at_modrm ? grp_op : op_reg);
	wire logic [7:0] use_modrm = at_modrm ? in_byte : modrm_reg;
	wire logic [2:0] sub_field = in_byte[5:3];
	wire logic reg_mode = in_byte[7:6] == `MOD_REG;
	wire logic modrm_bad = grp_op == op_none || (cls_reg.mem_only && reg_mode);
	// Immediate length: s set or byte width means one byte
	wire logic imm_byte = use_opc[1] | ~use_opc[0];
	wire logic [1:0] imm_last_idx = imm_byte ? 2'h0 : (op32 ? 2'h3 : 2'h1);
	wire logic imm_sext = use_opc[1] & use_opc[0];
	wire logic imm_take = state_reg == st_imm && in_valid;
	logic imm_last;
	logic [31:0] imm_value;

	byte_classifier u_classify (
		.esc(state_reg == st_escape),
		.opc(in_byte),
		.cls(cls_in)
	);

	immediate_gather u_imm (
		.clock(clock),
		.rst_n(rst_n),
		.take(imm_take),
		.in_byte(in_byte),
		.last_idx(imm_last_idx),
		.sext(imm_sext),
		.op32(op32),
		.last(imm_last),
		.value(imm_value)
	);

	// Middle field picks the operation for grouped opcodes
	always_comb begin
		grp_op = cls_reg.op;
		case (cls_reg.grp)
			grp_arith: begin
				case (sub_field)
					`ARITH_ADD: grp_op = add_op;
					`ARITH_ADC: grp_op = add_carry_op;
					`ARITH_BORROW: grp_op = subtract_with_borrow;
					`ARITH_SUB: grp_op = subtract_op;
					`ARITH_COMPARE: grp_op = compare_op;
					default: grp_op = op_none;
				endcase
			end
			grp_unary: begin
				case (sub_field)
					`UN_NEGATE: grp_op = negate_op;
					`UN_UMUL: grp_op = unsigned_multiply;
					`UN_SMUL: grp_op = signed_multiply;
					`UN_UDIVIDE: grp_op = unsigned_divide;
					default: grp_op = op_none;
				endcase
			end
			grp_pop: grp_op = sub_field == `POP_SUB ? pop_rm : op_none;
			grp_push: grp_op = sub_field == `PUSH_SUB ? push_rm : op_none;
			default: grp_op = cls_reg.op;
		endcase
	end

	// Sequencing through escape, operand specifier and immediate bytes
	always_comb begin
		state_next = state_reg;
		emit = 1'b0;
		bad = 1'b0;
		case (state_reg)
			st_opcode, st_escape: begin
				if (in_valid) begin
					if (state_reg == st_opcode && in_byte == `ESC_BYTE) begin
						state_next = st_escape;
					end else if (!cls_in.known) begin
						bad = 1'b1;
						state_next = st_opcode;
					end else if (cls_in.modrm) begin
						state_next = st_modrm;
					end else if (cls_in.has_imm) begin
						state_next = st_imm;
					end else begin
						emit = 1'b1;
						state_next = st_opcode;
					end
				end
			end
			st_modrm: begin
				if (in_valid) begin
					if (modrm_bad) begin
						bad = 1'b1;
						state_next = st_opcode;
					end else if (cls_reg.has_imm) begin
						state_next = st_imm;
					end else begin
						emit = 1'b1;
						state_next = st_opcode;
					end
				end
			end
			st_imm: begin
				if (imm_last) begin
					emit = 1'b1;
					state_next = st_opcode;
				end
			end
			default: state_next = st_opcode;
		endcase
	end

	// Decoded fields; unused ones read as zero, except wide, which reads as one
	always_comb begin
		dec_next = '0;
		dec_next.op = use_op;
		dec_next.wide = use_cls.has_w ? use_opc[0] : 1'b1;
		dec_next.dir = use_cls.dir;
		dec_next.mode = use_cls.modrm ? use_modrm[7:6] : 2'h0;
		dec_next.rm = use_cls.modrm ? use_modrm[2:0] : 3'h0;
		dec_next.reg_sel = use_cls.short_reg ? use_opc[2:0] : (use_cls.modrm ? use_modrm[5:3] : 3'h0);
		dec_next.seg = use_cls.seg;
		dec_next.has_imm = use_cls.has_imm;
		dec_next.imm = use_cls.has_imm ? imm_value : 32'h0000_0000;
	end

	// State and result pulses
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_reg <= st_opcode;
			dec_valid_reg <= 1'b0;
			dec_invalid_reg <= 1'b0;
			dec_reg <= '0;
		end else begin
			state_reg <= state_next;
			dec_valid_reg <= emit;
			dec_invalid_reg <= bad;
			if (emit) dec_reg <= dec_next;
		end
	end

	// Opcode context held while later bytes arrive
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			opc_reg <= 8'h00;
			cls_reg <= '0;
			op_reg <= op_none;
			modrm_reg <= 8'h00;
		end else if (fresh && in_valid) begin
			opc_reg <= in_byte;
			cls_reg <= cls_in;
			op_reg <= cls_in.op;
		end else if (at_modrm && in_valid) begin
			modrm_reg <= in_byte;
			op_reg <= grp_op;
		end
	end

	assign dec_valid = dec_valid_reg;
	assign dec_invalid = dec_invalid_reg;
	assign dec = dec_reg;

	// Checks on the decoded result
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	AST_ZERO_EXT: assert property ((opc_take && in_byte == `ESC_BYTE) ##1 (in_valid && in_byte ==? `X_ZERO_EXT)
		##1 in_valid |=> dec_valid && dec.op == zero_extend_move && dec.wide == $past(in_byte[0], 2)
		&& dec.reg_sel == $past(in_byte[5:3])) else $error("zero-extend move misdecoded");
	AST_PUSH_LEGACY: assert property (opc_take && in_byte ==? `P_PUSH_SEG |=> dec_valid && dec.op == push_seg
		&& dec.seg == {1'b0, $past(in_byte[4:3])}) else $error("legacy segment push wrong");
	AST_POP_RM: assert property ((opc_take && in_byte == `P_POP_RM) ##1 in_valid |=>
		($past(in_byte[5:3]) == `POP_SUB) ? (dec_valid && dec.op == pop_rm) : (dec_invalid && !dec_valid))
		else $error("pop of register or memory wrong");
	AST_POP_WIDE: assert property ((opc_take && in_byte == `ESC_BYTE) ##1 (in_valid && in_byte ==? `X_POP_SEG
		&& in_byte[5:3] == `SEG_GS) |=> dec_valid && dec.op == pop_seg && dec.seg == `SEG_GS)
		else $error("wide segment pop wrong");
	AST_SWAP: assert property (opc_take && in_byte ==? `P_SWAP |=> dec_valid && dec.op == swap_operands
		&& dec.reg_sel == $past(in_byte[2:0])) else $error("swap register field wrong");
	AST_LOAD_EA: assert property ((opc_take && in_byte == `P_LOAD_EA) ##1 (in_valid && !reg_mode) |=> dec_valid
		&& dec.op == load_effective_address && dec.dir && dec.reg_sel == $past(in_byte[5:3]))
		else $error("effective address load wrong");
	AST_FAR_DS: assert property ((opc_take && in_byte == `P_FAR_DS) ##1 (in_valid && !reg_mode) |=> dec_valid
		&& dec.op == far_load_data_seg && dec.seg == `SEG_DS) else $error("data segment far load wrong");
	AST_FAR_SS: assert property ((opc_take && in_byte == `ESC_BYTE) ##1 (in_valid && in_byte == `X_FAR_SS)
		##1 (in_valid && !reg_mode) |=> dec_valid && dec.op == far_load_stack_seg && dec.seg == `SEG_SS)
		else $error("stack segment far load wrong");
	AST_IRQ_FLAG: assert property (opc_take && (in_byte == `P_CLR_IE || in_byte == `P_SET_IE) |=> dec_valid
		&& !dec.has_imm && state_reg == st_opcode
		&& dec.op == ($past(in_byte[0]) ? set_irq_enable : clear_irq_enable))
		else $error("interrupt enable opcode wrong");
	AST_CLR_TS: assert property ((opc_take && in_byte == `ESC_BYTE) ##1 (in_valid && in_byte == `X_CLR_TS)
		|=> dec_valid && dec.op == clear_task_switched) else $error("task-switched clear wrong");
	AST_CARRY: assert property (opc_take && in_byte == `P_INV_CARRY |=> dec_valid && dec.op == invert_carry
		&& state_reg == st_opcode) else $error("carry invert wrong");
	AST_FLAG_BYTE: assert property (opc_take && in_byte == `P_FL_TO_ACC |=> dec_valid
		&& dec.op == flags_to_acc_high) else $error("flag byte copy wrong");
	AST_ARITH_DIR: assert property ((opc_take && in_byte ==? `P_SUB_RM) ##1 in_valid |=> dec_valid
		&& dec.op == subtract_op && dec.dir == $past(in_byte[1], 2) && dec.wide == $past(in_byte[0], 2))
		else $error("direction or width bit lost");
	AST_GRP_SEXT: assert property ((opc_take && in_byte ==? `P_GRP_ARITH && in_byte[1:0] == 2'h3)
		##1 (in_valid && sub_field == `ARITH_COMPARE) ##1 in_valid |=> dec_valid && dec.op == compare_op
		&& dec.imm[7:0] == $past(in_byte) && dec.imm[15:8] == {8{$past(in_byte[7])}})
		else $error("sign-extended immediate wrong");
	AST_ACC_FULL: assert property ((opc_take && in_byte ==? `P_SUB_AI && in_byte[0] && op32)
		##1 (in_valid && op32) [*4] |=> dec_valid && dec.op == subtract_op
		&& dec.imm[31:24] == $past(in_byte) && dec.reg_sel == 3'h0)
		else $error("accumulator immediate wrong");
	AST_UNARY: assert property ((opc_take && in_byte ==? `P_GRP_UNARY) ##1 (in_valid && sub_field == `UN_UDIVIDE)
		|=> dec_valid && dec.op == unsigned_divide) else $error("unary group divide wrong");
	AST_MUL_ESC: assert property ((opc_take && in_byte == `ESC_BYTE) ##1 (in_valid && in_byte == `X_PRODUCT_RR)
		##1 in_valid |=> dec_valid && dec.op == signed_multiply && dec.dir) else $error("multiply form wrong");
	AST_ADJUST: assert property (opc_take && in_byte == `P_PACK_SUB |=> dec_valid
		&& dec.op == packed_adjust_sub) else $error("decimal adjust wrong");
	AST_INVALID: assert property ((opc_take && in_byte == `P_GRP_FF) ##1 (in_valid && sub_field != `PUSH_SUB)
		|=> dec_invalid && !dec_valid && state_reg == st_opcode) else $error("invalid encoding accepted");

	COV_ESC_MOVE: cover property (dec_valid && dec.op == zero_extend_move);
	COV_FULL_IMM: cover property (dec_valid && dec.has_imm && op32 && !dec.imm[31]);
	COV_INVALID: cover property (dec_invalid);
	COV_BACK_TO_BACK: cover property (dec_valid ##1 dec_valid);

endmodule : opcode_decoder_core_ops

// file: decoder_cfg.svh
`ifndef DECODER_CFG_SVH
`define DECODER_CFG_SVH
// Summary of operation
// - Escape plus 1011011w: zero-extending register move
// - 000ss110 pushes a legacy segment register
// - Pop forms: 8F /0, 000ss111, escape 10sss001
// - 10010rrr swaps register with accumulator
// - 8D loads effective address into reg
// - C5/C4 far loads with data/extra segment
// - Escape B4/B5/B2 far load third/fourth/stack
// - FA clears, FB sets interrupt enable
// - Escape then 06 clears task-switched flag
// - F5 inverts, F9 sets carry, FD sets direction
// - 9F flags to high byte, 9E back
// - Register/memory add, carry, subtract, borrow, compare forms
// - 100000sw immediate op chosen by middle field
// - Accumulator short immediate arithmetic forms
// - 1111011w: negate, multiply, signed multiply, divide
// - Escape AF and 011010s1 signed multiply forms
// - 37, 27, 2F decimal adjustment opcodes
// - Reg field picks register, width bit picks set
// - Direction bit swaps source and destination roles
// - Sign bit extends byte immediate to width

// Prefix byte and primary opcode patterns
`define ESC_BYTE 8'h0F
`define P_ADD_RM 8'b000000??
`define P_ADC_RM 8'b000100??
`define P_BORROW_RM 8'b000110??
`define P_SUB_RM 8'b001010??
`define P_COMPARE_RM 8'b001110??
`define P_ADD_AI 8'b0000010?
`define P_ADC_AI 8'b0001010?
`define P_BORROW_AI 8'b0001110?
`define P_SUB_AI 8'b0010110?
`define P_COMPARE_AI 8'b0011110?
`define P_PUSH_SEG 8'b000??110
`define P_POP_SEG 8'b000??111
`define P_PACK_ADD 8'h27
`define P_PACK_SUB 8'h2F
`define P_UNPACK_ADD 8'h37
`define P_PRODUCT_IMM 8'b011010?1
`define P_GRP_ARITH 8'b100000??
`define P_LOAD_EA 8'h8D
`define P_POP_RM 8'h8F
`define P_SWAP 8'b10010???
`define P_ACC_TO_FL 8'h9E
`define P_FL_TO_ACC 8'h9F
`define P_FAR_ES 8'hC4
`define P_FAR_DS 8'hC5
`define P_INV_CARRY 8'hF5
`define P_GRP_UNARY 8'b1111011?
`define P_SET_CARRY 8'hF9
`define P_CLR_IE 8'hFA
`define P_SET_IE 8'hFB
`define P_SET_DIR 8'hFD
`define P_GRP_FF 8'hFF
// Second byte after the escape
`define X_CLR_TS 8'h06
`define X_PRODUCT_RR 8'hAF
`define X_FAR_SS 8'hB2
`define X_FAR_FS 8'hB4
`define X_FAR_GS 8'hB5
`define X_ZERO_EXT 8'b1011011?
`define X_PUSH_SEG 8'b10???000
`define X_POP_SEG 8'b10???001
// Operand-specifier middle fields and mode
`define ARITH_ADD 3'h0
`define ARITH_ADC 3'h2
`define ARITH_BORROW 3'h3
`define ARITH_SUB 3'h5
`define ARITH_COMPARE 3'h7
`define UN_NEGATE 3'h3
`define UN_UMUL 3'h4
`define UN_SMUL 3'h5
`define UN_UDIVIDE 3'h6
`define POP_SUB 3'h0
`define PUSH_SUB 3'h6
`define MOD_REG 2'h3
// Segment register codes
`define SEG_ES 3'h0
`define SEG_CS 3'h1
`define SEG_SS 3'h2
`define SEG_DS 3'h3
`define SEG_FS 3'h4
`define SEG_GS 3'h5
// Classification flag bits
`define F_RM 6'h20
`define F_W 6'h10
`define F_IMM 6'h08
`define F_DIR 6'h04
`define F_SHORT 6'h02
`define F_MEM 6'h01
`define F_NONE 6'h00
`endif

// file: decoder_pkg.sv
package decoder_pkg;

	typedef enum logic [5:0] {
		op_none, zero_extend_move, push_seg, push_rm, pop_seg, pop_rm,
		swap_operands, load_effective_address, far_load_data_seg, far_load_extra_seg,
		far_load_third_seg, far_load_fourth_seg, far_load_stack_seg, clear_irq_enable,
		set_irq_enable, clear_task_switched, invert_carry, set_carry, set_direction,
		flags_to_acc_high, acc_high_to_flags, add_op, add_carry_op, subtract_op,
		subtract_with_borrow, compare_op, negate_op, unsigned_multiply, signed_multiply,
		unsigned_divide, unpacked_adjust_add, packed_adjust_add, packed_adjust_sub
	} op_t;

	typedef enum logic [2:0] {grp_none, grp_arith, grp_unary, grp_pop, grp_push} grp_t;

	typedef enum logic [1:0] {st_opcode, st_escape, st_modrm, st_imm} state_t;

	// What the opcode byte alone tells us
	typedef struct packed {
		op_t op;
		grp_t grp;
		logic known;
		logic modrm;
		logic has_w;
		logic has_imm;
		logic dir;
		logic short_reg;
		logic mem_only;
		logic [2:0] seg;
	} class_t;

	// Decoded instruction handed to the datapath
	typedef struct packed {
		op_t op;
		logic wide;
		logic dir;
		logic [1:0] mode;
		logic [2:0] reg_sel;
		logic [2:0] rm;
		logic [2:0] seg;
		logic has_imm;
		logic [31:0] imm;
	} dec_out_t;

endpackage : decoder_pkg

// file: byte_classifier.sv
`include "decoder_cfg.svh"
module byte_classifier
	import decoder_pkg::*;
(
	input wire logic esc,
	input wire logic [7:0] opc,
	output class_t cls
);

	logic [5:0] dirf;
	logic wide_seg;

	// Packs one table entry
	function automatic class_t cl(op_t op, grp_t g, logic [5:0] f, logic [2:0] seg);
		class_t c;
		c.op = op;
		c.grp = g;
		c.known = 1'b1;
		{c.modrm, c.has_w, c.has_imm, c.dir, c.short_reg, c.mem_only} = f;
		c.seg = seg;
		return c;
	endfunction : cl

	assign dirf = opc[1] ? `F_DIR : `F_NONE;
	assign wide_seg = opc[5:3] == `SEG_FS || opc[5:3] == `SEG_GS;

	// First match wins; anything unlisted stays unknown
	always_comb begin
		cls = '0;
		if (esc) begin
			casez (opc)
				`X_CLR_TS: cls = cl(clear_task_switched, grp_none, `F_NONE, `SEG_ES);
				`X_PRODUCT_RR: cls = cl(signed_multiply, grp_none, `F_RM | `F_DIR, `SEG_ES);
				`X_FAR_SS: cls = cl(far_load_stack_seg, grp_none, `F_RM | `F_DIR | `F_MEM, `SEG_SS);
				`X_FAR_FS: cls = cl(far_load_third_seg, grp_none, `F_RM | `F_DIR | `F_MEM, `SEG_FS);
				`X_FAR_GS: cls = cl(far_load_fourth_seg, grp_none, `F_RM | `F_DIR | `F_MEM, `SEG_GS);
				`X_ZERO_EXT: cls = cl(zero_extend_move, grp_none, `F_RM | `F_W | `F_DIR, `SEG_ES);
				`X_PUSH_SEG: cls = wide_seg ? cl(push_seg, grp_none, `F_NONE, opc[5:3]) : '0;
				`X_POP_SEG: cls = wide_seg ? cl(pop_seg, grp_none, `F_NONE, opc[5:3]) : '0;
				default: cls = '0;
			endcase
		end else begin
			casez (opc)
				`P_ADD_RM: cls = cl(add_op, grp_none, `F_RM | `F_W | dirf, `SEG_ES);
				`P_ADC_RM: cls = cl(add_carry_op, grp_none, `F_RM | `F_W | dirf, `SEG_ES);
				`P_BORROW_RM: cls = cl(subtract_with_borrow, grp_none, `F_RM | `F_W | dirf, `SEG_ES);
				`P_SUB_RM: cls = cl(subtract_op, grp_none, `F_RM | `F_W | dirf, `SEG_ES);
				`P_COMPARE_RM: cls = cl(compare_op, grp_none, `F_RM | `F_W | dirf, `SEG_ES);
				`P_ADD_AI: cls = cl(add_op, grp_none, `F_W | `F_IMM, `SEG_ES);
				`P_ADC_AI: cls = cl(add_carry_op, grp_none, `F_W | `F_IMM, `SEG_ES);
				`P_BORROW_AI: cls = cl(subtract_with_borrow, grp_none, `F_W | `F_IMM, `SEG_ES);
				`P_SUB_AI: cls = cl(subtract_op, grp_none, `F_W | `F_IMM, `SEG_ES);
				`P_COMPARE_AI: cls = cl(compare_op, grp_none, `F_W | `F_IMM, `SEG_ES);
				`P_PUSH_SEG: cls = cl(push_seg, grp_none, `F_NONE, {1'b0, opc[4:3]});
				`P_POP_SEG: cls = opc[4:3] != 2'h1 ? cl(pop_seg, grp_none, `F_NONE, {1'b0, opc[4:3]}) : '0;
				`P_PACK_ADD: cls = cl(packed_adjust_add, grp_none, `F_NONE, `SEG_ES);
				`P_PACK_SUB: cls = cl(packed_adjust_sub, grp_none, `F_NONE, `SEG_ES);
				`P_UNPACK_ADD: cls = cl(unpacked_adjust_add, grp_none, `F_NONE, `SEG_ES);
				`P_PRODUCT_IMM: cls = cl(signed_multiply, grp_none, `F_RM | `F_IMM | `F_DIR, `SEG_ES);
				`P_GRP_ARITH: cls = cl(op_none, grp_arith, `F_RM | `F_W | `F_IMM, `SEG_ES);
				`P_LOAD_EA: cls = cl(load_effective_address, grp_none, `F_RM | `F_DIR | `F_MEM, `SEG_ES);
				`P_POP_RM: cls = cl(op_none, grp_pop, `F_RM, `SEG_ES);
				`P_SWAP: cls = cl(swap_operands, grp_none, `F_SHORT, `SEG_ES);
				`P_ACC_TO_FL: cls = cl(acc_high_to_flags, grp_none, `F_NONE, `SEG_ES);
				`P_FL_TO_ACC: cls = cl(flags_to_acc_high, grp_none, `F_NONE, `SEG_ES);
				`P_FAR_ES: cls = cl(far_load_extra_seg, grp_none, `F_RM | `F_DIR | `F_MEM, `SEG_ES);
				`P_FAR_DS: cls = cl(far_load_data_seg, grp_none, `F_RM | `F_DIR | `F_MEM, `SEG_DS);
				`P_INV_CARRY: cls = cl(invert_carry, grp_none, `F_NONE, `SEG_ES);
				`P_GRP_UNARY: cls = cl(op_none, grp_unary, `F_RM | `F_W, `SEG_ES);
				`P_SET_CARRY: cls = cl(set_carry, grp_none, `F_NONE, `SEG_ES);
				`P_CLR_IE: cls = cl(clear_irq_enable, grp_none, `F_NONE, `SEG_ES);
				`P_SET_IE: cls = cl(set_irq_enable, grp_none, `F_NONE, `SEG_ES);
				`P_SET_DIR: cls = cl(set_direction, grp_none, `F_NONE, `SEG_ES);
				`P_GRP_FF: cls = cl(op_none, grp_push, `F_RM, `SEG_ES);
				default: cls = '0;
			endcase
		end
	end

endmodule : byte_classifier

// file: immediate_gather.sv
module immediate_gather
	import decoder_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic take,
	input wire logic [7:0] in_byte,
	input wire logic [1:0] last_idx,
	input wire logic sext,
	input wire logic op32,
	output logic last,
	output logic [31:0] value
);

	logic [1:0] idx_reg;
	logic [31:0] hold_reg;
	logic [31:0] raw;

	// Little-endian lanes; the arriving byte bypasses the hold so the value is ready on the last byte
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_lane
			wire logic [7:0] lane = (take && idx_reg == 2'(g)) ? in_byte : hold_reg[8 * g +: 8];
			assign raw[8 * g +: 8] = (2'(g) <= last_idx) ? lane : 8'h00;
		end
	endgenerate

	assign last = take && idx_reg == last_idx;
	// Byte immediate widened to the operand width only when asked
	assign value = (sext && last_idx == 2'h0) ? (op32 ? {{24{raw[7]}}, raw[7:0]} :
		{16'h0000, {8{raw[7]}}, raw[7:0]}) : raw;

	// Lane index rewinds after each immediate
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			idx_reg <= 2'h0;
			hold_reg <= 32'h0000_0000;
		end else if (take) begin
			hold_reg[8 * idx_reg +: 8] <= in_byte;
			idx_reg <= last ? 2'h0 : idx_reg + 2'h1;
		end
	end

endmodule : immediate_gather

// file: fetch_model.sv
module fetch_model (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic slow,
	output logic in_valid,
	output logic [7:0] in_byte,
	output logic op32
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [8:0] q[$];
	logic [8:0] cur;
	integer seed = 60;
	initial begin
		in_valid = 1'b0;
		in_byte = 8'h00;
		op32 = 1'b1;
	end
	// One byte a cycle, random stalls when slow; op32 holds across stalls
	always @(posedge clock) begin
		if (rst_n && q.size() != 0 && !(slow && $random(seed) % 2 != 0)) begin
			cur = q.pop_front();
			in_valid <= 1'b1;
			in_byte <= cur[7:0];
			op32 <= cur[8];
		end else begin
			in_valid <= 1'b0;
			in_byte <= ~in_byte; // Stale byte must not look valid
		end
	end
endmodule : fetch_model

// file: testbench.sv
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_mismatch++; $display("Error at %0t: got %0h expected %0h", $time, a, e); end end
module testbench;
	import decoder_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	// mr: check flag, width bit, operand specifier
	typedef struct packed {logic inv; op_t op; logic [2:0] rs; logic [1:0] d; logic [3:0] s; logic [32:0] im;
		logic [9:0] mr;} exp_t;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic slow = 1'b0;
	logic in_valid, op32, dec_valid, dec_invalid;
	logic [7:0] in_byte;
	dec_out_t dec;
	exp_t exq[$];
	exp_t e;
	integer seed = 60;
	int n_mismatch = 0;
	int checked = 0;
	logic [7:0] sb[10] = '{8'hFA, 8'hFB, 8'hF5, 8'hF9, 8'hFD, 8'h9F, 8'h9E, 8'h37, 8'h27, 8'h2F};
	op_t so[10] = '{clear_irq_enable, set_irq_enable, invert_carry, set_carry, set_direction,
		flags_to_acc_high, acc_high_to_flags, unpacked_adjust_add, packed_adjust_add, packed_adjust_sub};
	op_t aop[5] = '{add_op, add_carry_op, subtract_with_borrow, subtract_op, compare_op};
	logic [7:0] rmb[5] = '{8'h00, 8'h10, 8'h18, 8'h28, 8'h38};
	logic [2:0] mid[5] = '{3'h0, 3'h2, 3'h3, 3'h5, 3'h7};
	op_t uop[4] = '{negate_op, unsigned_multiply, signed_multiply, unsigned_divide};
	opcode_decoder_core_ops i_opcode_decoder_core_ops (.clock(clock), .rst_n(rst_n), .in_valid(in_valid),
		.in_byte(in_byte), .op32(op32), .dec_valid(dec_valid), .dec_invalid(dec_invalid), .dec(dec));
	fetch_model i_fetch_model (.clock(clock), .rst_n(rst_n), .slow(slow), .in_valid(in_valid),
		.in_byte(in_byte), .op32(op32));
	initial begin
		forever #50 clock = ~clock;
	end
	// Immediate length and value as the fetch stage pairs the bytes
	function automatic int ilen(logic [7:0] o, logic o32);
		return (o[1] | !o[0]) ? 1 : (o32 ? 4 : 2);
	endfunction : ilen
	function automatic logic [32:0] iexp(logic [7:0] o, logic o32, logic [31:0] r);
		int l = ilen(o, o32);
		logic [31:0] v = (l == 1) ? {24'h0, r[7:0]} : (l == 2) ? {16'h0, r[15:0]} : r;
		if (o[1] & o[0]) v = o32 ? {{24{r[7]}}, r[7:0]} : {16'h0, {8{r[7]}}, r[7:0]};
		return {1'b1, v};
	endfunction : iexp
	task automatic add(int n, logic [55:0] b, logic o32, op_t op, logic [2:0] rs, logic [1:0] d, logic [3:0] s,
		logic [32:0] im, logic inv, logic [9:0] mr = 10'h000);
		exq.push_back('{inv, op, rs, d, s, im, mr});
		for (int j = 0; j < n; j++) i_fetch_model.q.push_back({o32, b[8 * j +: 8]});
	endtask : add
	task automatic fx(int n, logic [55:0] b, op_t op, logic [2:0] rs, logic [1:0] d, logic [3:0] s);
		add(n, b, 1'b1, op, rs, d, s, 33'h0, 1'b0);
	endtask : fx
	task automatic bad(int n, logic [55:0] b);
		add(n, b, 1'b1, op_none, 3'h0, 2'h0, 4'h0, 33'h0, 1'b1);
	endtask : bad
	task automatic drain();
		int t;
		for (t = 0; t < 5000 && (i_fetch_model.q.size() != 0 || exq.size() != 0); t++) @(posedge clock);
		if (t == 5000) n_mismatch++;
	endtask : drain
	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : end_of_test
	// Every result pulse is matched against the oldest expectation; d and s only where known
	always @(posedge clock) begin
		if ((dec_valid | dec_invalid) === 1'b1) begin
			if (exq.size() == 0) `CHK(1'b0, 1'b1)
			else begin
				e = exq.pop_front();
				`CHK(dec_invalid, e.inv)
				if (!e.inv) begin
					`CHK(dec.op, e.op)
					`CHK(dec.reg_sel, e.rs)
					if (e.d[1]) `CHK(dec.dir, e.d[0])
					if (e.s[3]) `CHK(dec.seg, e.s[2:0])
					if (e.im[32]) `CHK(dec.imm, e.im[31:0])
					`CHK(dec.has_imm, e.im[32])
					if (e.mr[9]) `CHK({dec.wide, dec.mode, dec.reg_sel, dec.rm}, e.mr[8:0])
				end
			end
		end
	end
	initial begin
		logic [31:0] r, r2;
		logic [7:0] o, m;
		logic [9:0] mw;
		int k;
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		for (int i = 0; i < 10; i++) fx(1, sb[i], so[i], 3'h0, 2'h0, 4'h0);
		fx(2, 56'h060F, clear_task_switched, 3'h0, 2'h0, 4'h0);
		fx(3, 56'hC1B60F, zero_extend_move, 3'h0, 2'h3, 4'h0);
		fx(3, 56'hDAB70F, zero_extend_move, 3'h3, 2'h3, 4'h0);
		for (int i = 0; i < 4; i++) begin
			fx(1, {3'h0, 2'(i), 3'h6}, push_seg, 3'h0, 2'h0, {2'h2, 2'(i)});
			if (i != 1) fx(1, {3'h0, 2'(i), 3'h7}, pop_seg, 3'h0, 2'h0, {2'h2, 2'(i)});
			fx(2, {2'h3, 3'(i + 3), 3'h1, 8'hF7}, uop[i], 3'(i + 3), 2'h0, 4'h0);
		end
		fx(2, 56'hC38F, pop_rm, 3'h0, 2'h0, 4'h0);
		fx(2, 56'hA10F, pop_seg, 3'h0, 2'h0, 4'hC);
		fx(2, 56'hA90F, pop_seg, 3'h0, 2'h0, 4'hD);
		for (int i = 0; i < 8; i++) fx(1, {5'h12, 3'(i)}, swap_operands, 3'(i), 2'h0, 4'h0);
		fx(2, 56'h188D, load_effective_address, 3'h3, 2'h3, 4'h0);
		fx(2, 56'h08C5, far_load_data_seg, 3'h1, 2'h3, 4'hB);
		fx(2, 56'h10C4, far_load_extra_seg, 3'h2, 2'h3, 4'h8);
		fx(3, 56'h18B40F, far_load_third_seg, 3'h3, 2'h3, 4'hC);
		fx(3, 56'h20B50F, far_load_fourth_seg, 3'h4, 2'h3, 4'hD);
		fx(3, 56'h28B20F, far_load_stack_seg, 3'h5, 2'h3, 4'hA);
		fx(3, 56'hC8AF0F, signed_multiply, 3'h1, 2'h3, 4'h0);
		add(6, 56'h12345678C369, 1'b1, signed_multiply, 3'h0, 2'h0, 4'h0, {1'b1, 32'h12345678}, 1'b0);
		add(3, 56'h80D96B, 1'b1, signed_multiply, 3'h3, 2'h0, 4'h0, {1'b1, 32'hFFFFFF80}, 1'b0);
		add(3, 56'h221105, 1'b0, add_op, 3'h0, 2'h0, 4'h0, {1'b1, 32'h2211}, 1'b0);
		add(3, 56'h80F883, 1'b0, compare_op, 3'h7, 2'h0, 4'h0, {1'b1, 32'hFF80}, 1'b0);
		fx(2, 56'h30FF, push_rm, 3'h6, 2'h0, 4'h0);
		fx(2, 56'hA00F, push_seg, 3'h0, 2'h0, 4'hC);
		add(5, 56'h443322112D, 1'b1, subtract_op, 3'h0, 2'h0, 4'h0, {1'b1, 32'h44332211}, 1'b0, 10'h300);
		// Unassigned encodings, sent back to back with no valid one between them
		bad(2, 56'hC0FF);
		bad(2, 56'h0F0F);
		bad(1, 56'h40);
		bad(2, 56'hC08D);
		bad(2, 56'hC88F);
		bad(2, 56'hF8F7);
		bad(2, 56'hC880);
		drain();
		slow <= 1'b1;
		// Random arithmetic forms, with fetch stalls
		for (int i = 0; i < 60; i++) begin
			k = $unsigned($random(seed)) % 5;
			r = $random(seed);
			r2 = $random(seed);
			m = {2'h3, r[13:8]};
			if (i % 3 == 1) m[5:3] = mid[k];
			// Width bit is opcode bit 0; accumulator forms carry no specifier
			mw = {1'b1, r[16], (i % 3 == 2) ? 8'h00 : m};
			if (i % 3 == 0) begin
				add(2, {m, rmb[k] | r[17:16]}, r[31], aop[k], m[5:3], {1'b1, r[17]}, 4'h0, 33'h0, 1'b0, mw);
			end else if (i % 3 == 1) begin
				o = 8'h80 | r[17:16];
				add(2 + ilen(o, r[31]), {r2, m, o}, r[31], aop[k], mid[k], 2'h0, 4'h0, iexp(o, r[31], r2), 1'b0, mw);
			end else begin
				o = rmb[k] | 8'h04 | r[16];
				add(1 + ilen(o, r[31]), {r2, o}, r[31], aop[k], 3'h0, 2'h0, 4'h0, iexp(o, r[31], r2), 1'b0, mw);
			end
		end
		drain();
		end_of_test();
	end
endmodule : testbench
